//--- design/ssf_pkg.sv
// constants, types and field layouts of the supply supervisor and serial front end
// assumes a 100 MHz system clock and a host that masters the 24-bit serial frame
package ssf_pkg;

  localparam int CLK_MHZ         = 100;
  localparam int SCK_MAX_KHZ     = 4000;
  localparam int FRAME_BITS      = 24;
  localparam int CNT_W           = 5;
  localparam int TMR_W           = 16;
  localparam int DATA_W          = 16;
  localparam int ADDR_W          = 6;
  localparam int OP_W            = 2;

  localparam int SPI_TIMEOUT_US  = 20;
  localparam int SPI_TIMEOUT_CYC = SPI_TIMEOUT_US * CLK_MHZ;
  localparam int CORE_FILTER_US  = 10;
  localparam int CORE_FILTER_CYC = CORE_FILTER_US * CLK_MHZ;
  localparam int IO_UV_DELAY_US  = 100;
  localparam int IO_UV_DELAY_CYC = IO_UV_DELAY_US * CLK_MHZ;

  localparam logic [CNT_W-1:0] FRAME_LEN = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] LAST_BIT  = CNT_W'(FRAME_BITS - 1);

  // frame layout: opcode, address, data
  localparam int OP_LO   = 22;
  localparam int ADDR_LO = 16;

  localparam logic [OP_W-1:0]   OP_READ  = 2'h0;
  localparam logic [OP_W-1:0]   OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0]   OP_RDCLR = 2'h2;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_DIAG = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_CORE = 6'h13;

  // control word bits; the actuation restart and standby bits are strobes, not stored
  localparam int CTRL_GATE_RST  = 0;
  localparam int CTRL_FRAME_RST = 1;
  localparam int CTRL_ACT_RST   = 2;
  localparam int CTRL_FAULT_SEL = 3;
  localparam int CTRL_STBY      = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0001;
  localparam logic [DATA_W-1:0] CTRL_MASK  = 16'h000b;

  typedef struct packed {
    logic supply_low;
    logic supply_overvoltage_status;
    logic io_supply_uv_level;
    logic io_supply_sleep_level;
    logic core_rail_uv_level;
    logic core_rail_reset_level;
  } ssf_cmp_t;

  typedef struct packed {
    logic supply_low_flag;
    logic supply_overvoltage_flag;
    logic reset_occurred_flag;
    logic core_rail_undervoltage_flag;
  } ssf_diag_t;

  typedef enum logic [1:0] {ST_SLEEP, ST_STANDBY, ST_ACTIVE, ST_CORE_RST} ssf_mode_t;

endpackage : ssf_pkg

//--- design/ssf_spi_link.sv
// serial-clock side of the front end: receive shifter, edge counter, output bit
// assumes the serial clock idles low and lnk_clr is released before the first edge
`timescale 1ns/10ps
module ssf_spi_link import ssf_pkg::*; (
  input  wire logic                  sck,
  input  wire logic                  lnk_clr,
  input  wire logic                  sdi,
  input  wire logic [FRAME_BITS-1:0] tx_word,
  output logic      [FRAME_BITS-1:0] rx_word,
  output logic      [CNT_W-1:0]      rise_cnt,
  output logic                       sdo_bit
);

  logic [CNT_W-1:0] fall_cnt_q;

  always_ff @(posedge sck or posedge lnk_clr) begin
    if (lnk_clr) begin
      rx_word  <= '0;
      rise_cnt <= '0;
    end else begin
      rx_word <= {rx_word[FRAME_BITS-2:0], sdi};
      // saturates so that an overlong frame never wraps back to a legal count
      if (rise_cnt != '1) begin
        rise_cnt <= rise_cnt + 1'b1;
      end
    end
  end

  always_ff @(negedge sck or posedge lnk_clr) begin
    if (lnk_clr) begin
      fall_cnt_q <= '0;
    end else if (fall_cnt_q != FRAME_LEN) begin
      fall_cnt_q <= fall_cnt_q + 1'b1;
    end
  end

  // tx_word is frozen by the system side for the whole frame
  assign sdo_bit = (fall_cnt_q < FRAME_LEN) ? tx_word[LAST_BIT - fall_cnt_q] : 1'b0;

endmodule : ssf_spi_link

//--- design/ssf_supervisor.sv
// supply supervision, mode control and serial frame decoding on the system clock
// assumes comparator levels and pins are asynchronous; link logic sits in ssf_spi_link
`timescale 1ns/10ps
module ssf_supervisor import ssf_pkg::*; #(
  parameter int IO_UV_CYC = IO_UV_DELAY_CYC
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe_n,
  input  wire logic act_gate,
  input  ssf_cmp_t  cmp_in,
  output logic      drive_en,
  output logic      fault_pin,
  output logic      regulator_en,
  output ssf_mode_t mode,
  output ssf_diag_t diag
);

  localparam int SYNC_W = 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h01;
  localparam logic [TMR_W-1:0] CORE_LIM = TMR_W'(CORE_FILTER_CYC);
  localparam logic [TMR_W-1:0] IO_LIM   = TMR_W'(IO_UV_CYC);
  localparam logic [TMR_W-1:0] TO_LIM   = TMR_W'(SPI_TIMEOUT_CYC);

  logic [SYNC_W-1:0]     sync1_q;
  logic [SYNC_W-1:0]     sync2_q;
  ssf_cmp_t              cmp_s;
  logic                  gate_s;
  logic                  cs_s;
  logic                  cs_q;
  logic                  gate_q;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  gate_rise;
  logic [TMR_W-1:0]      to_cnt_q;
  logic                  timeout_q;
  logic                  lnk_clr_q;
  logic [FRAME_BITS-1:0] rx_word;
  logic [CNT_W-1:0]      rise_cnt;
  logic                  sdo_bit;
  logic [FRAME_BITS-1:0] rx_q;
  logic                  exec_q;
  logic                  frame_err_q;
  logic                  done_q;
  logic [OP_W-1:0]       op;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wdata;
  logic                  wr_ctrl;
  logic                  rdclr_diag;
  logic                  rdclr_core;
  logic [DATA_W-1:0]     ctrl_q;
  logic [DATA_W-1:0]     rd_data;
  logic [FRAME_BITS-1:0] tx_q;
  ssf_mode_t             mode_q;
  logic [TMR_W-1:0]      core_cnt_q;
  logic [TMR_W-1:0]      io_cnt_q;
  logic                  core_hold;
  logic                  io_uv_done;
  logic                  por;
  logic                  all_clr;
  logic                  ctl_clr;
  ssf_diag_t             diag_q;
  logic                  global_fault;
  logic                  ready;
  logic                  restart;
  logic                  act_q;
  logic                  fault_q;

  // two-stage synchroniser for every asynchronous level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= {cmp_in, act_gate, cs_n};
      sync2_q <= sync1_q;
    end
  end

  assign cmp_s  = ssf_cmp_t'(sync2_q[SYNC_W-1:2]);
  assign gate_s = sync2_q[1];
  assign cs_s   = sync2_q[0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cs_q   <= 1'b1;
      gate_q <= 1'b0;
    end else begin
      cs_q   <= cs_s;
      gate_q <= gate_s;
    end
  end

  assign cs_fall   = cs_q & ~cs_s;
  assign cs_rise   = ~cs_q & cs_s;
  assign gate_rise = ~gate_q & gate_s;

  // frame timeout: a stuck chip select releases the output and voids the frame
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      to_cnt_q  <= '0;
      timeout_q <= 1'b0;
    end else if (cs_s) begin
      to_cnt_q  <= '0;
      timeout_q <= 1'b0;
    end else if (to_cnt_q == TO_LIM) begin
      timeout_q <= 1'b1;
    end else begin
      to_cnt_q <= to_cnt_q + 1'b1;
    end
  end

  // link clear is dropped on chip select fall, raised again after capture;
  // the host must leave a few system cycles before the first serial edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lnk_clr_q <= 1'b1;
    end else if (cs_fall) begin
      lnk_clr_q <= 1'b0;
    end else if (cs_rise) begin
      lnk_clr_q <= 1'b1;
    end
  end

  ssf_spi_link u_link (
    .sck      (sck),
    .lnk_clr  (lnk_clr_q),
    .sdi      (sdi),
    .tx_word  (tx_q),
    .rx_word  (rx_word),
    .rise_cnt (rise_cnt),
    .sdo_bit  (sdo_bit)
  );

  assign sdo      = sdo_bit;
  assign sdo_oe_n = cs_s | timeout_q;

  // link words are quiet here: the serial clock is stopped low at chip select rise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_q        <= '0;
      exec_q      <= 1'b0;
      frame_err_q <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      exec_q <= 1'b0;
      done_q <= cs_rise;
      if (cs_rise) begin
        rx_q <= rx_word;
        if ((rise_cnt == FRAME_LEN) && !timeout_q) begin
          exec_q      <= 1'b1;
          frame_err_q <= 1'b0;
        end else begin
          frame_err_q <= 1'b1;
        end
      end
    end
  end

  assign op         = rx_q[FRAME_BITS-1:OP_LO];
  assign addr       = rx_q[OP_LO-1:ADDR_LO];
  assign wdata      = rx_q[DATA_W-1:0];
  assign wr_ctrl    = exec_q && (op == OP_WRITE) && (addr == ADDR_CTRL);
  assign rdclr_diag = exec_q && (op == OP_RDCLR) && (addr == ADDR_DIAG);
  assign rdclr_core = exec_q && (op == OP_RDCLR) && (addr == ADDR_CORE);

  // persistence filters restart whenever the condition goes away
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      core_cnt_q <= '0;
    end else if (!cmp_s.core_rail_reset_level) begin
      core_cnt_q <= '0;
    end else if (core_cnt_q != CORE_LIM) begin
      core_cnt_q <= core_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_cnt_q <= '0;
    end else if (!cmp_s.io_supply_uv_level) begin
      io_cnt_q <= '0;
    end else if (io_cnt_q != IO_LIM) begin
      io_cnt_q <= io_cnt_q + 1'b1;
    end
  end

  assign core_hold  = (core_cnt_q == CORE_LIM);
  assign io_uv_done = (io_cnt_q == IO_LIM);
  assign por        = (mode_q == ST_SLEEP) && !cmp_s.io_supply_sleep_level;
  assign all_clr    = core_hold | por;
  assign ctl_clr    = all_clr | io_uv_done;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= ST_STANDBY;
    end else if (core_hold) begin
      mode_q <= ST_CORE_RST;
    end else if (cmp_s.io_supply_sleep_level) begin
      mode_q <= ST_SLEEP;
    end else begin
      unique case (mode_q)
        ST_SLEEP:    mode_q <= ST_STANDBY;
        ST_CORE_RST: mode_q <= ST_STANDBY;
        ST_STANDBY: begin
          if (cs_fall && !cmp_s.io_supply_uv_level) begin
            mode_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (cmp_s.io_supply_uv_level || (wr_ctrl && wdata[CTRL_STBY])) begin
            mode_q <= ST_STANDBY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctl_clr) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata & CTRL_MASK;
    end
  end

  // sticky flags: a new event in a read-clear cycle wins over the read-clear; a core hold or power-on clear wins over the event
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      diag_q <= '0;
      diag_q.reset_occurred_flag <= 1'b1;
    end else if (all_clr) begin
      diag_q <= '0;
      diag_q.reset_occurred_flag <= 1'b1;
    end else begin
      if (cmp_s.supply_low) begin
        diag_q.supply_low_flag <= 1'b1;
      end else if (rdclr_diag) begin
        diag_q.supply_low_flag <= 1'b0;
      end
      if (cmp_s.supply_overvoltage_status) begin
        diag_q.supply_overvoltage_flag <= 1'b1;
      end else if (rdclr_diag) begin
        diag_q.supply_overvoltage_flag <= 1'b0;
      end
      if (exec_q) begin
        diag_q.reset_occurred_flag <= 1'b0;
      end
      if (cmp_s.core_rail_uv_level) begin
        diag_q.core_rail_undervoltage_flag <= 1'b1;
      end else if (rdclr_core) begin
        diag_q.core_rail_undervoltage_flag <= 1'b0;
      end
    end
  end

  assign global_fault = diag_q.supply_low_flag | diag_q.supply_overvoltage_flag
                      | diag_q.core_rail_undervoltage_flag;

  always_comb begin
    rd_data = '0;
    unique case (addr)
      ADDR_CTRL: rd_data = ctrl_q;
      ADDR_DIAG: rd_data = DATA_W'({diag_q.supply_low_flag, diag_q.supply_overvoltage_flag,
                                    diag_q.reset_occurred_flag});
      ADDR_CORE: rd_data = DATA_W'(diag_q.core_rail_undervoltage_flag);
      default:   rd_data = '0;
    endcase
  end

  // answer of a frame goes out in the next one; only changes while deselected
  // loaded at every frame end so that a refused frame still reports its error bit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= '0;
    end else if (done_q) begin
      tx_q <= {frame_err_q, global_fault, mode_q, diag_q, rd_data};
    end
  end

  // no fault, core rail fine and device active
  assign ready = !cmp_s.supply_low && !cmp_s.supply_overvoltage_status
              && !cmp_s.core_rail_uv_level && (mode_q == ST_ACTIVE);

  assign restart = (gate_rise && ctrl_q[CTRL_GATE_RST])
                || (exec_q && ctrl_q[CTRL_FRAME_RST])
                || (wr_ctrl && wdata[CTRL_ACT_RST]);

  // disabling wins over any restart request in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      act_q <= 1'b0;
    end else if (!gate_s || !ready || ctl_clr) begin
      act_q <= 1'b0;
    end else if (restart) begin
      act_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= ctrl_q[CTRL_FAULT_SEL] ? act_q : global_fault;
    end
  end

  assign drive_en     = act_q;
  assign fault_pin    = fault_q;
  assign regulator_en = (mode_q != ST_SLEEP);
  assign mode         = mode_q;
  assign diag         = diag_q;

  AST_GATE_LOW_DISABLES: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !gate_s |=> !drive_en) else $error("actuation left on with gate low");

  AST_FAULT_PIN_GLOBAL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !ctrl_q[CTRL_FAULT_SEL] |=> (fault_pin == $past(global_fault)))
    else $error("fault pin does not follow global fault");

  AST_SDO_RELEASED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $past(cs_n, 2) |-> sdo_oe_n) else $error("serial output driven while released");

  AST_BAD_FRAME_DROPPED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cs_rise && (rise_cnt != FRAME_LEN)) |=> (!exec_q && frame_err_q))
    else $error("frame of wrong length executed");

  AST_LOW_SUPPLY: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmp_s.supply_low && !all_clr) |=> (diag.supply_low_flag && !drive_en))
    else $error("supply low not flagged or outputs on");

  AST_OVERVOLTAGE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmp_s.supply_overvoltage_status && !all_clr) |=> (diag.supply_overvoltage_flag && !drive_en))
    else $error("overvoltage not flagged or outputs on");

  AST_SLEEP_ENTRY: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmp_s.io_supply_sleep_level && !core_hold) |=> (mode == ST_SLEEP && !regulator_en))
    else $error("sleep not entered");

  AST_CORE_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    core_hold |=> (mode == ST_CORE_RST && ctrl_q == CTRL_RESET && diag.reset_occurred_flag))
    else $error("core reset not held");

  AST_RESET_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (exec_q && !all_clr) |=> !diag.reset_occurred_flag)
    else $error("reset flag survives communication");

  AST_WAKE_FROM_SLEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (por && !core_hold) |=> (mode == ST_STANDBY) ##1 (mode != ST_ACTIVE || $past(cs_fall)))
    else $error("sleep exit not to standby");

endmodule : ssf_supervisor

//--- dv/ssf_host_model.sv
// host-side serial master model: drives chip select, serial clock and data in
// assumes one frame at a time from the bench; the sdo line has a pull-up
`timescale 1ns/10ps
module ssf_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // nb other than 24 breaks the frame on purpose; hold_ns stretches cs low
  task automatic xfer(input logic [23:0] w, input int nb, input int hold_ns,
                      output logic [23:0] r);
    r    = 24'h0;
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < nb; i++) begin
      sdi = w[23 - (i % 24)];
      #62.5;
      // released line reads as the pull-up level
      r   = {r[22:0], sdo_oe_n ? 1'b1 : sdo};
      sck = 1'b1;
      #62.5;
      sck = 1'b0;
    end
    #(100 + hold_ns);
    cs_n = 1'b1;
    sdi  = ~sdi;
    #150;
  endtask : xfer
endmodule : ssf_host_model

//--- dv/supply_supervisor_serial_front_end_tb.sv
// self-checking bench for the supply supervisor and serial front end
// assumes the host model in ssf_host_model; io undervoltage delay shortened
`timescale 1ns/10ps
module supply_supervisor_serial_front_end_tb;
  import ssf_pkg::*;
  localparam int IO_UV_SIM = 20;
  logic        clk_sys, arst_n, sck, cs_n, sdi, sdo, sdo_oe_n;
  logic        act_gate, drive_en, fault_pin, regulator_en;
  ssf_cmp_t    cmp_in;
  ssf_mode_t   mode;
  ssf_diag_t   diag;
  logic [23:0] rx;
  logic [15:0] ctrl_exp;
  int          failures, checked, cyc, seed;
  int          cbit[3]  = '{5, 4, 1};
  int          fbit[3]  = '{3, 2, 0};
  logic [5:0]  raddr[3] = '{ADDR_DIAG, ADDR_DIAG, ADDR_CORE};
  int          nbad[2]  = '{23, 25};

  ssf_supervisor #(.IO_UV_CYC(IO_UV_SIM)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .act_gate(act_gate), .cmp_in(cmp_in),
    .drive_en(drive_en), .fault_pin(fault_pin), .regulator_en(regulator_en),
    .mode(mode), .diag(diag));
  ssf_host_model host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : ticks

  function automatic logic [23:0] word(input logic [1:0] op, input logic [5:0] a,
                                       input logic [15:0] d);
    return {op, a, d};
  endfunction : word

  function automatic logic [3:0] dexp(input logic low, input logic ov, input logic rst,
                                      input logic core);
    return {low, ov, rst, core};
  endfunction : dexp

  task automatic frame(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    host.xfer(word(op, a, d), 24, 0, rx);
    ticks(4);
  endtask : frame

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    seed     = 90469;
    arst_n   = 1'b0;
    act_gate = 1'b0;
    cmp_in   = '0;
    ctrl_exp = CTRL_RESET;
    ticks(16);
    arst_n = 1'b1;
    ticks(4);
    chk(mode, ST_STANDBY);
    chk(diag, dexp(1'b0, 1'b0, 1'b1, 1'b0));
    chk(sdo_oe_n, 1'b1);
    chk(drive_en, 1'b0);
    chk(fault_pin, 1'b0);
    frame(OP_READ, ADDR_CTRL, 16'($random(seed)));
    chk(mode, ST_ACTIVE);
    chk(diag, dexp(1'b0, 1'b0, 1'b0, 1'b0));
    frame(OP_READ, ADDR_CTRL, 16'h0000);
    chk(rx[15:0], CTRL_RESET);
    chk(rx[23:20], 4'h2);
    done("reset_and_readback");
    for (int k = 0; k < 3; k++) begin
      act_gate = 1'b0;
      ticks(6);
      chk(drive_en, 1'b0);
      act_gate = 1'b1;
      ticks(6);
      chk(drive_en, 1'b1);
      cmp_in = '0;
      cmp_in[cbit[k]] = 1'b1;
      ticks(6);
      chk(drive_en, 1'b0);
      chk(diag[fbit[k]], 1'b1);
      chk(fault_pin, 1'b1);
      cmp_in = '0;
      ticks(6);
      chk(diag[fbit[k]], 1'b1);
      chk(drive_en, 1'b0);
      if (k == 0) begin
        act_gate = 1'b0;
        ticks(6);
        act_gate = 1'b1;
        ticks(6);
      end else if (k == 1) begin
        frame(OP_WRITE, ADDR_CTRL, 16'h0005);
      end else begin
        frame(OP_WRITE, ADDR_CTRL, 16'h0003);
        ctrl_exp = 16'h0003;
        frame(OP_READ, ADDR_DIAG, 16'h0000);
      end
      chk(drive_en, 1'b1);
      frame(OP_RDCLR, raddr[k], 16'($random(seed)));
      chk(diag[fbit[k]], 1'b0);
      chk(fault_pin, 1'b0);
    end
    chk(rx, {1'b0, 1'b1, ST_ACTIVE, dexp(1'b0, 1'b0, 1'b0, 1'b1), 16'h0000});
    done("supply_faults");
    foreach (nbad[j]) begin
      host.xfer(word(OP_WRITE, ADDR_CTRL, 16'h0008), nbad[j], 0, rx);
      ticks(4);
      frame(OP_READ, ADDR_CTRL, 16'($random(seed)));
      chk(rx[23], 1'b1);
      frame(OP_READ, ADDR_CTRL, 16'h0000);
      chk(rx[23], 1'b0);
      chk(rx[15:0], ctrl_exp);
    end
    fork
      host.xfer(word(OP_WRITE, ADDR_CTRL, 16'h0009), 24, 25000, rx);
      begin
        ticks(100);
        chk(sdo_oe_n, 1'b0);
        ticks(2200);
        chk(sdo_oe_n, 1'b1);
      end
    join
    ticks(4);
    frame(OP_READ, ADDR_CTRL, 16'h0000);
    chk(rx[23], 1'b1);
    frame(OP_READ, ADDR_CTRL, 16'h0000);
    chk(rx[15:0], ctrl_exp);
    done("bad_frames");
    frame(OP_WRITE, ADDR_CTRL, 16'h0009);
    act_gate = 1'b0;
    ticks(6);
    chk(fault_pin, 1'b0);
    act_gate = 1'b1;
    ticks(6);
    chk(fault_pin, 1'b1);
    cmp_in.io_supply_uv_level = 1'b1;
    ticks(6);
    chk(mode, ST_STANDBY);
    chk(drive_en, 1'b0);
    ticks(IO_UV_SIM * 2);
    cmp_in = '0;
    ticks(6);
    frame(OP_READ, ADDR_CTRL, 16'h0000);
    frame(OP_READ, ADDR_CTRL, 16'h0000);
    chk(rx[15:0], CTRL_RESET);
    chk(mode, ST_ACTIVE);
    done("io_undervoltage");
    frame(OP_WRITE, ADDR_CTRL, 16'h0010);
    chk(mode, ST_STANDBY);
    cmp_in.io_supply_sleep_level = 1'b1;
    ticks(6);
    chk(mode, ST_SLEEP);
    chk(regulator_en, 1'b0);
    cmp_in = '0;
    ticks(6);
    chk(mode, ST_STANDBY);
    chk(regulator_en, 1'b1);
    chk(diag, dexp(1'b0, 1'b0, 1'b1, 1'b0));
    done("sleep");
    frame(OP_READ, ADDR_CTRL, 16'h0000);
    cmp_in.core_rail_reset_level = 1'b1;
    ticks(100 + ($random(seed) & 255));
    cmp_in = '0;
    ticks(6);
    chk(mode, ST_ACTIVE);
    cmp_in.core_rail_reset_level = 1'b1;
    ticks(1100);
    chk(mode, ST_CORE_RST);
    chk(drive_en, 1'b0);
    cmp_in = '0;
    ticks(6);
    chk(mode, ST_STANDBY);
    chk(diag, dexp(1'b0, 1'b0, 1'b1, 1'b0));
    done("core_rail_reset");
    end_of_test();
  end
endmodule : supply_supervisor_serial_front_end_tb
